/* File: bench/cpi_link_props.sv */
`timescale 1ns/10ps
module cpi_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe,
    input wire logic sda_dev_out,
    input wire logic sda_host_oe,
    input wire logic supply_low
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    AST_DRIVE_ON_LOW: assert property ($rose(sda_dev_oe) |-> !scl)
        else $error("Slave began driving SDA while SCL was high.");
    AST_ACK_LENGTH: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
        else $error("Slave drive on SDA was too short.");
    AST_HOLD_HIGH: assert property (scl && $past(scl) && !supply_low |->
        $stable(sda_dev_oe) && $stable(sda_dev_out))
        else $error("Slave changed SDA while SCL was high.");
    AST_IDLE_AFTER_START: assert property (s_start |=> !sda_dev_oe [*8])
        else $error("Slave drove SDA just after a START.");
    AST_IDLE_AFTER_STOP: assert property (s_stop |=> !sda_dev_oe [*8])
        else $error("Slave drove SDA just after a STOP.");
    AST_SUPPLY_ABORT: assert property (supply_low [*4] |-> !sda_dev_oe)
        else $error("Slave kept driving SDA in a supply drop.");
    AST_START_BY_HOST: assert property (s_start |-> sda_host_oe)
        else $error("START formed without the host pulling SDA.");
    AST_STOP_BY_HOST: assert property (s_stop |-> $past(sda_host_oe))
        else $error("STOP formed without the host owning SDA.");
    AST_SCL_PHASE: assert property ($changed(scl) |=> $stable(scl) [*7])
        else $error("Serial clock phase shorter than expected.");
endmodule : cpi_link_props

/* File: bench/test_companion_i2c_slave_rtc_control.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module test_companion_i2c_slave_rtc_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic tick_second = 1'b0;
    logic [7:0] control_reg;
    logic [7:0] calibration_reg;
    logic [7:0] live_seconds;
    logic [7:0] live_years;
    logic calibration_out;
    logic memory_selected;
    logic [8:0] wire_bits = 9'h000;
    int n_errors = 0;
    int num_checks = 0;
    cpi_link_if link();
    cpi_slave u_cpi_slave (.pclk(pclk), .presetn(presetn), .link(link.device),
        .select_pins(2'b10), .tick_second(tick_second), .control_reg(control_reg),
        .calibration_reg(calibration_reg), .live_seconds(live_seconds), .live_years(live_years),
        .calibration_out(calibration_out), .memory_selected(memory_selected));
    cpi_master u_cpi_master (.pclk(pclk), .presetn(presetn), .link(link.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr());
    cpi_link_props u_cpi_link_props (.pclk(pclk), .presetn(presetn), .scl(link.scl),
        .sda(link.sda), .sda_dev_oe(link.sda_dev_oe), .sda_dev_out(link.sda_dev_out),
        .sda_host_oe(link.sda_host_oe), .supply_low(link.supply_low));
    initial forever #5 pclk = ~pclk;
    initial link.supply_low = 1'b0;
    always @(posedge link.scl) wire_bits <= {wire_bits[7:0], link.sda};
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish(input bit hung);
        if (hung) n_errors++;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) tally_and_finish(1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic xfer(input logic [7:0] b, input logic [4:0] f, output logic [7:0] q,
        output logic nak);
        logic [31:0] s;
        int i;
        apb(1'b1, cpi_pkg::APB_CMD, {19'h0_0000, f, b}, s);
        for (i = 0; i < 400; i++) begin
            apb(1'b0, cpi_pkg::APB_STATUS, 32'h0000_0000, s);
            if (s[0] === 1'b0) break;
        end
        if (i == 400) tally_and_finish(1'b1);
        nak = s[1];
        apb(1'b0, cpi_pkg::APB_RDATA, 32'h0000_0000, s);
        q = s[7:0];
    endtask : xfer
    task automatic wreg(input logic [7:0] off, input logic [7:0] d);
        logic [7:0] q;
        logic k;
        xfer(8'hD4, 5'h03, q, k);
        `CHK("address ack", 1'b0, k)
        xfer(off, 5'h01, q, k);
        `CHK("offset ack", 1'b0, k)
        xfer(d, 5'h05, q, k);
        `CHK("data ack", 1'b0, k)
    endtask : wreg
    task automatic tick();
        @(posedge pclk);
        tick_second <= 1'b1;
        @(posedge pclk);
        tick_second <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : tick
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("scl idle", 1'b1, link.scl)
        `CHK("sda idle", 1'b1, link.sda)
        `CHK("control reset", cpi_pkg::CTL_RESET, control_reg)
        `CHK("calibration reset", cpi_pkg::CAL_RESET, calibration_reg)
        $display("done t_reset");
    endtask : t_reset
    task automatic t_cal();
        logic c;
        wreg(cpi_pkg::OFF_CONTROL, 8'h04);
        `CHK("cal mode", 8'h04, control_reg)
        c = calibration_out;
        tick();
        `CHK("cal out toggles", ~c, calibration_out)
        wreg(cpi_pkg::OFF_CALIBRATION, 8'h25);
        `CHK("cal written", 8'h25, calibration_reg)
        wreg(cpi_pkg::OFF_CONTROL, 8'h00);
        `CHK("cal out off", 1'b0, calibration_out)
        wreg(cpi_pkg::OFF_CALIBRATION, 8'h3F);
        `CHK("cal locked", 8'h25, calibration_reg)
        $display("done t_cal");
    endtask : t_cal
    task automatic t_time();
        logic [7:0] q;
        logic k;
        wreg(cpi_pkg::OFF_CONTROL, 8'h02);
        wreg(cpi_pkg::OFF_SECONDS, 8'h45);
        `CHK("frozen live", 8'h01, live_seconds)
        wreg(cpi_pkg::OFF_CONTROL, 8'h00);
        `CHK("loaded live", 8'h45, live_seconds)
        tick();
        wreg(cpi_pkg::OFF_CONTROL, 8'h01);
        tick();
        xfer(8'hD4, 5'h03, q, k);
        xfer(cpi_pkg::OFF_CALIBRATION, 5'h01, q, k);
        xfer(8'hD5, 5'h03, q, k);
        xfer(8'hFF, 5'h09, q, k);
        `CHK("read first", 8'h25, q)
        xfer(8'hFF, 5'h1D, q, k);
        `CHK("read snapshot", 8'h46, q)
        $display("done t_time");
    endtask : t_time
    task automatic t_addr();
        logic [7:0] q;
        logic k;
        xfer(8'hD0, 5'h03, q, k);
        `CHK("wrong select", 1'b1, k)
        xfer(8'hA4, 5'h03, q, k);
        `CHK("memory ack", 1'b0, k)
        `CHK("memory selected", 1'b1, memory_selected)
        xfer(8'hD4, 5'h03, q, k);
        xfer(8'h19, 5'h05, q, k);
        `CHK("offset refused", 1'b1, k)
        xfer(8'hD4, 5'h03, q, k);
        xfer(8'h18, 5'h01, q, k);
        `CHK("last offset", 1'b0, k)
        `CHK("wire bits", {8'h18, 1'b0}, wire_bits)
        xfer(8'hD4, 5'h07, q, k);
        xfer(8'h00, 5'h01, q, k);
        `CHK("idle after stop", 1'b1, k)
        $display("done t_addr");
    endtask : t_addr
    task automatic t_abort();
        logic [7:0] q;
        logic k;
        xfer(8'hD4, 5'h03, q, k);
        xfer(cpi_pkg::OFF_CONTROL, 5'h01, q, k);
        xfer(8'hD4, 5'h03, q, k);
        `CHK("restart ack", 1'b0, k)
        xfer(cpi_pkg::OFF_CONTROL, 5'h01, q, k);
        link.supply_low <= 1'b1;
        repeat (8) @(posedge pclk);
        link.supply_low <= 1'b0;
        xfer(8'h02, 5'h01, q, k);
        `CHK("aborted data", 1'b1, k)
        `CHK("control kept", 8'h01, control_reg)
        xfer(8'hD4, 5'h07, q, k);
        $display("done t_abort");
    endtask : t_abort
    task automatic t_century();
        wreg(cpi_pkg::OFF_SECONDS, 8'h59);
        wreg(cpi_pkg::OFF_YEARS, 8'h99);
        `CHK("years loaded", 8'h99, live_years)
        tick();
        `CHK("seconds wrap", 8'h00, live_seconds)
        `CHK("year wrap", 8'h00, live_years)
        `CHK("century flag", 8'h41, control_reg)
        $display("done t_century");
    endtask : t_century
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_cal();
        t_time();
        t_addr();
        t_abort();
        t_century();
        tally_and_finish(1'b0);
    end
endmodule : test_companion_i2c_slave_rtc_control

/* File: hw/cpi_link_if.sv */
`timescale 1ns/10ps
interface cpi_link_if;
    logic scl;
    logic sda_dev_out;
    logic sda_dev_oe;
    logic sda_host_out;
    logic sda_host_oe;
    logic sda;
    logic supply_low;
    // Open drain wire: any enabled low driver pulls low.
    assign sda = !((sda_dev_oe && !sda_dev_out) || (sda_host_oe && !sda_host_out));
    modport device (input scl, input sda, input supply_low, output sda_dev_out, output sda_dev_oe);
    modport host (output scl, input sda, output sda_host_out, output sda_host_oe);
endinterface : cpi_link_if

/* File: hw/cpi_master.sv */
`timescale 1ns/10ps
module cpi_master (
    input wire logic pclk,
    input wire logic presetn,
    cpi_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [2:0] {
        CPM_IDLE = 3'b000,
        CPM_START = 3'b001,
        CPM_BIT = 3'b010,
        CPM_ACK = 3'b011,
        CPM_STOP = 3'b100
    } cpm_state_t;

    cpm_state_t state, next_state;
    logic [15:0] div, next_div, cnt, next_cnt;
    logic [1:0] phase, next_phase;
    logic [3:0] bits, next_bits;
    logic [7:0] sh, next_sh, rbuf, next_rbuf;
    logic [4:0] cmd, next_cmd;
    logic scl_o, next_scl, sda_o, next_sda, ack_in, next_ack_in;
    logic [1:0] sda_sync;
    logic tick, busy;
    logic wr;

    assign tick = (cnt == 16'h0000);
    assign busy = (state != CPM_IDLE);
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        if (paddr == cpi_pkg::APB_STATUS) begin
            prdata = {30'h0000_0000, ack_in, busy};
        end else if (paddr == cpi_pkg::APB_RDATA) begin
            prdata = {24'h00_0000, rbuf};
        end else if (paddr == cpi_pkg::APB_DIV) begin
            prdata = {16'h0000, div};
        end else begin
            prdata = 32'h0000_0000;
        end
    end

    always_comb begin
        next_state = state;
        next_div = div;
        next_cnt = tick ? div : cnt - 16'h0001;
        next_phase = phase;
        next_bits = bits;
        next_sh = sh;
        next_rbuf = rbuf;
        next_cmd = cmd;
        next_scl = scl_o;
        next_sda = sda_o;
        next_ack_in = ack_in;
        if (wr && paddr == cpi_pkg::APB_DIV) begin
            next_div = pwdata[15:0];
        end
        if (wr && paddr == cpi_pkg::APB_CMD && !busy && pwdata[cpi_pkg::CMD_GO_BIT]) begin
            next_cmd = pwdata[12:8];
            next_sh = pwdata[7:0];
            next_state = pwdata[cpi_pkg::CMD_START_BIT] ? CPM_START : CPM_BIT;
            next_phase = 2'd0;
            next_bits = 4'd0;
        end else if (busy && tick) begin
            next_phase = phase + 2'd1;
            case (state)
                CPM_START: begin
                    if (phase == 2'd0) begin
                        next_sda = 1'b1;
                        next_scl = 1'b1;
                    end else if (phase == 2'd1) begin
                        next_sda = 1'b0;
                    end else if (phase == 2'd2) begin
                        next_scl = 1'b0;
                        next_state = CPM_BIT;
                        next_phase = 2'd0;
                    end
                end
                CPM_BIT: begin
                    if (phase == 2'd0) begin
                        next_sda = cmd[3] ? 1'b1 : sh[7];
                    end else if (phase == 2'd1) begin
                        next_scl = 1'b1;
                    end else if (phase == 2'd2) begin
                        next_rbuf = {rbuf[6:0], sda_sync[1]};
                    end else begin
                        next_scl = 1'b0;
                        next_sh = {sh[6:0], 1'b0};
                        next_bits = bits + 4'd1;
                        next_state = (bits == 4'd7) ? CPM_ACK : CPM_BIT;
                    end
                end
                CPM_ACK: begin
                    if (phase == 2'd0) begin
                        next_sda = cmd[3] ? cmd[4] : 1'b1;
                    end else if (phase == 2'd1) begin
                        next_scl = 1'b1;
                    end else if (phase == 2'd2) begin
                        next_ack_in = sda_sync[1];
                    end else begin
                        next_scl = 1'b0;
                        next_state = cmd[2] ? CPM_STOP : CPM_IDLE;
                    end
                end
                CPM_STOP: begin
                    if (phase == 2'd0) begin
                        next_sda = 1'b0;
                    end else if (phase == 2'd1) begin
                        next_scl = 1'b1;
                    end else if (phase == 2'd2) begin
                        next_sda = 1'b1;
                        next_state = CPM_IDLE;
                    end
                end
                default: begin
                    next_state = CPM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CPM_IDLE;
            div <= cpi_pkg::DIV_RESET;
            cnt <= 16'h0000;
            phase <= 2'd0;
            bits <= 4'd0;
            sh <= 8'h00;
            rbuf <= 8'h00;
            cmd <= 5'h00;
            scl_o <= 1'b1;
            sda_o <= 1'b1;
            ack_in <= 1'b1;
            sda_sync <= 2'b11;
        end else begin
            state <= next_state;
            div <= next_div;
            cnt <= next_cnt;
            phase <= next_phase;
            bits <= next_bits;
            sh <= next_sh;
            rbuf <= next_rbuf;
            cmd <= next_cmd;
            scl_o <= next_scl;
            sda_o <= next_sda;
            ack_in <= next_ack_in;
            sda_sync <= {sda_sync[0], link.sda};
        end
    end
    assign link.scl = scl_o;
    assign link.sda_host_out = 1'b0;
    assign link.sda_host_oe = !sda_o;
endmodule : cpi_master

/* File: hw/cpi_pkg.sv */
package cpi_pkg;
    localparam logic [3:0] ID_MEMORY = 4'b1010;
    localparam logic [3:0] ID_COMPANION = 4'b1101;
    localparam logic [7:0] REG_LAST = 8'h18;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CALIBRATION = 8'h01;
    localparam logic [7:0] OFF_SECONDS = 8'h02;
    localparam logic [7:0] OFF_MINUTES = 8'h03;
    localparam logic [7:0] OFF_HOURS = 8'h04;
    localparam logic [7:0] OFF_YEARS = 8'h08;
    localparam int CTL_READ_BIT = 0;
    localparam int CTL_FREEZE_BIT = 1;
    localparam int CTL_CALMODE_BIT = 2;
    localparam int CTL_CENTURY_BIT = 6;
    localparam int CAL_DISABLE_BIT = 7;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h47;
    localparam logic [7:0] CAL_MAG_SIGN_MASK = 8'h3F;
    localparam logic [7:0] CAL_DISABLE_MASK = 8'h80;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CAL_RESET = 8'h00;
    localparam int CAL_TOGGLE_CYCLES = 1;
    // Host APB registers.
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_WDATA = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam logic [7:0] APB_RDATA = 8'h0C;
    localparam logic [7:0] APB_DIV = 8'h10;
    localparam logic [15:0] DIV_RESET = 16'h0008;
    localparam int CMD_GO_BIT = 8;
    localparam int CMD_START_BIT = 9;
    localparam int CMD_STOP_BIT = 10;
    localparam int CMD_READ_BIT = 11;
    localparam int CMD_NACK_BIT = 12;
endpackage : cpi_pkg

/* File: hw/cpi_slave.sv */
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module cpi_slave (
    input wire logic pclk,
    input wire logic presetn,
    cpi_link_if.device link,
    input wire logic [1:0] select_pins,
    input wire logic tick_second,
    output logic [7:0] control_reg,
    output logic [7:0] calibration_reg,
    output logic [7:0] live_seconds,
    output logic [7:0] live_years,
    output logic calibration_out,
    output logic memory_selected
);
    typedef enum logic [2:0] {
        CPI_IDLE = 3'b000,
        CPI_ADDR = 3'b001,
        CPI_REG = 3'b010,
        CPI_WRITE = 3'b011,
        CPI_READ = 3'b100,
        CPI_SKIP = 3'b101
    } cpi_state_t;
    function automatic logic [7:0] cpi_bcd_inc(input logic [7:0] v, input logic [7:0] top);
        if (v >= top) begin
            cpi_bcd_inc = 8'h00;
        end else if (v[3:0] == 4'h9) begin
            cpi_bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            cpi_bcd_inc = v + 8'h01;
        end
    endfunction : cpi_bcd_inc
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and condition detection.
    logic [2:0] scl_sync, sda_sync;
    logic [1:0] low_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync <= 3'b111;
            sda_sync <= 3'b111;
            low_sync <= 2'b00;
        end else begin
            scl_sync <= {scl_sync[1:0], link.scl};
            sda_sync <= {sda_sync[1:0], link.sda};
            low_sync <= {low_sync[0], link.supply_low};
        end
    end
    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_sync[1] && !scl_sync[2];
    assign scl_fall = !scl_sync[1] && scl_sync[2];
    assign start_seen = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
    assign stop_seen = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine state.
    cpi_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift, reg_ptr, next_reg_ptr, rd_data, user_sec, user_year;
    logic ack_phase, next_ack_phase, drive_low, next_drive_low, mem_sel, next_mem_sel, wr_stb;
    logic [7:0] wr_addr, wr_data;

    always_comb begin
        rd_data = 8'h00;
        if (reg_ptr == cpi_pkg::OFF_CONTROL) begin
            rd_data = control_reg;
        end else if (reg_ptr == cpi_pkg::OFF_CALIBRATION) begin
            rd_data = calibration_reg;
        end else if (reg_ptr == cpi_pkg::OFF_SECONDS) begin
            rd_data = user_sec;
        end else if (reg_ptr == cpi_pkg::OFF_YEARS) begin
            rd_data = user_year;
        end
    end

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_reg_ptr = reg_ptr;
        next_ack_phase = ack_phase;
        next_drive_low = drive_low;
        next_mem_sel = mem_sel;
        wr_stb = 1'b0;
        wr_addr = reg_ptr;
        wr_data = shift;
        if (low_sync[1] || stop_seen) begin
            next_state = CPI_IDLE;
            next_drive_low = 1'b0;
            next_mem_sel = 1'b0;
        end else if (start_seen) begin
            next_state = CPI_ADDR;
            next_bit_cnt = 4'h0;
            next_ack_phase = 1'b0;
            next_drive_low = 1'b0;
            next_mem_sel = 1'b0;
        end else if (state == CPI_SKIP && scl_fall) begin
            next_drive_low = 1'b0;
        end else if (state != CPI_IDLE && state != CPI_SKIP) begin
            if (scl_rise && !ack_phase) begin
                next_bit_cnt = bit_cnt + 4'h1;
                if (state != CPI_READ) begin
                    next_shift = {shift[6:0], sda_sync[1]};
                end
            end else if (scl_rise && state == CPI_READ && sda_sync[1]) begin
                next_state = CPI_SKIP;
            end else if (scl_fall) begin
                if (ack_phase) begin
                    next_ack_phase = 1'b0;
                    next_bit_cnt = 4'h0;
                    next_drive_low = 1'b0;
                    if (state == CPI_READ) begin
                        next_shift = rd_data;
                        next_drive_low = !rd_data[7];
                        next_reg_ptr = reg_ptr + 8'h01;
                    end
                end else if (bit_cnt == 4'h8) begin
                    next_ack_phase = 1'b1;
                    next_drive_low = 1'b1;
                    case (state)
                        CPI_ADDR: begin
                            if (shift[2:1] != select_pins) begin
                                next_state = CPI_SKIP;
                                next_drive_low = 1'b0;
                            end else if (shift[7:4] == cpi_pkg::ID_MEMORY) begin
                                next_mem_sel = 1'b1;
                                next_state = CPI_SKIP;
                            end else if (shift[7:4] == cpi_pkg::ID_COMPANION) begin
                                next_state = shift[0] ? CPI_READ : CPI_REG;
                            end else begin
                                next_state = CPI_SKIP;
                                next_drive_low = 1'b0;
                            end
                        end
                        CPI_REG: begin
                            if (shift > cpi_pkg::REG_LAST) begin
                                next_state = CPI_SKIP;
                                next_drive_low = 1'b0;
                            end else begin
                                next_reg_ptr = shift;
                                next_state = CPI_WRITE;
                            end
                        end
                        CPI_WRITE: begin
                            wr_stb = 1'b1;
                            next_reg_ptr = reg_ptr + 8'h01;
                        end
                        default: begin
                            next_drive_low = 1'b0;
                        end
                    endcase
                end else if (state == CPI_READ) begin
                    next_shift = {shift[6:0], 1'b1};
                    next_drive_low = !shift[6];
                end
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CPI_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            reg_ptr <= 8'h00;
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
            mem_sel <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            reg_ptr <= next_reg_ptr;
            ack_phase <= next_ack_phase;
            drive_low <= next_drive_low;
            mem_sel <= next_mem_sel;
        end
    end
    assign link.sda_dev_out = 1'b0;
    assign link.sda_dev_oe = drive_low;
    assign memory_selected = mem_sel;
    ////////////////////////////////////////////////////////////////////////////
    // Control, calibration and timekeeping registers.
    logic [7:0] next_control, next_calibration, next_live_sec, next_live_year;
    logic [7:0] next_user_sec, next_user_year;
    logic cal_toggle, next_cal_toggle;
    always_comb begin
        next_control = control_reg;
        next_calibration = calibration_reg;
        next_live_sec = live_seconds;
        next_live_year = live_years;
        next_user_sec = user_sec;
        next_user_year = user_year;
        next_cal_toggle = cal_toggle ^ tick_second;
        if (tick_second) begin
            next_live_sec = cpi_bcd_inc(live_seconds, 8'h59);
            if (live_seconds == 8'h59) begin
                next_live_year = cpi_bcd_inc(live_years, 8'h99);
                if (live_years == 8'h99) begin
                    next_control[cpi_pkg::CTL_CENTURY_BIT] = 1'b1;
                end
            end
        end
        if (wr_stb && wr_addr == cpi_pkg::OFF_CONTROL) begin
            next_control = (wr_data & cpi_pkg::CTL_WRITE_MASK)
                | (next_control & 8'h40 & {8{tick_second && live_years == 8'h99}});
            if (wr_data[cpi_pkg::CTL_READ_BIT] && !control_reg[cpi_pkg::CTL_READ_BIT]) begin
                next_user_sec = live_seconds;
                next_user_year = live_years;
            end
            if (!wr_data[cpi_pkg::CTL_FREEZE_BIT] && control_reg[cpi_pkg::CTL_FREEZE_BIT]) begin
                next_live_sec = user_sec;
                next_live_year = user_year;
            end
        end else if (wr_stb && wr_addr == cpi_pkg::OFF_CALIBRATION) begin
            next_calibration = (calibration_reg & ~cpi_pkg::CAL_DISABLE_MASK)
                | (wr_data & cpi_pkg::CAL_DISABLE_MASK);
            if (control_reg[cpi_pkg::CTL_CALMODE_BIT]) begin
                next_calibration = (next_calibration & ~cpi_pkg::CAL_MAG_SIGN_MASK)
                    | (wr_data & cpi_pkg::CAL_MAG_SIGN_MASK);
            end
        end else if (wr_stb && wr_addr == cpi_pkg::OFF_SECONDS) begin
            next_user_sec = wr_data;
            if (!control_reg[cpi_pkg::CTL_FREEZE_BIT]) begin
                next_live_sec = wr_data;
            end
        end else if (wr_stb && wr_addr == cpi_pkg::OFF_YEARS) begin
            next_user_year = wr_data;
            if (!control_reg[cpi_pkg::CTL_FREEZE_BIT]) begin
                next_live_year = wr_data;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= cpi_pkg::CTL_RESET;
            calibration_reg <= cpi_pkg::CAL_RESET;
            live_seconds <= 8'h00;
            live_years <= 8'h00;
            user_sec <= 8'h00;
            user_year <= 8'h00;
            cal_toggle <= 1'b0;
            calibration_out <= 1'b0;
        end else begin
            control_reg <= next_control;
            calibration_reg <= next_calibration;
            live_seconds <= next_live_sec;
            live_years <= next_live_year;
            user_sec <= next_user_sec;
            user_year <= next_user_year;
            cal_toggle <= next_cal_toggle;
            calibration_out <= control_reg[cpi_pkg::CTL_CALMODE_BIT] && cal_toggle;
        end
    end
endmodule : cpi_slave
